// [common/haptic_cfg_pkg.sv]
// Constants shared by the haptic drive configuration register slice
package haptic_cfg_pkg;

	// Register offsets, one byte each on the register port
	localparam logic [7:0] ADDR_RATING    = 8'h0e;
	localparam logic [7:0] ADDR_FACTOR_HI = 8'h0f;
	localparam logic [7:0] ADDR_FACTOR_LO = 8'h10;
	localparam logic [7:0] ADDR_IMP_HI    = 8'h11;
	localparam logic [7:0] ADDR_IMP_LO    = 8'h12;
	localparam logic [7:0] ADDR_DRIVE_CFG = 8'h13;
	localparam logic [7:0] ADDR_MEM_BRAKE = 8'h14;
	localparam logic [7:0] ADDR_HEADROOM  = 8'h15;
	localparam logic [7:0] ADDR_UPD_CTL   = 8'h16;

	// Values after reset
	localparam logic [4:0] RST_RATING    = 5'h17;
	localparam logic [7:0] RST_FACTOR_HI = 8'h01;
	localparam logic [7:0] RST_FACTOR_LO = 8'h0d;
	localparam logic [7:0] RST_IMP_HI    = 8'h00;
	localparam logic [1:0] RST_IMP_LO    = 2'h0;
	localparam logic [7:0] RST_DRIVE_CFG = 8'h1e;
	localparam logic [4:0] RST_MEM_BRAKE = 5'h01;
	localparam logic [3:0] RST_HEADROOM  = 4'h3;
	localparam logic [7:0] RST_UPD_CTL   = 8'h40;
	localparam logic [7:0] RDATA_IDLE    = 8'h00;

	// Writable bits of the drive configuration register, bit 6 reserved
	localparam logic [7:0] DRIVE_CFG_MASK = 8'hbf;
	localparam logic [7:0] UPD_CTL_MASK   = 8'hc0;

	// Field positions in the drive configuration register
	localparam int BIT_AUTO_FAULT_CLR = 7;
	localparam int BIT_ACTUATOR_ERM   = 5;
	localparam int BIT_BACKEMF_LOOP   = 4;
	localparam int BIT_FREQ_TRACK     = 3;
	localparam int BIT_ACCEL          = 2;
	localparam int BIT_FAST_BRAKE     = 1;
	localparam int BIT_AMP_LOOP       = 0;

	// Field positions in the memory and brake register
	localparam int BIT_MEM_SIGNED = 4;

	// Field positions in the update control register
	localparam int BIT_UPD_HOLD      = 7;
	localparam int BIT_UPD_HOLD_PLAY = 6;

	// Conversion factor arithmetic: Z = code * 62.5 mohm, factor = Z * (rating + 4) / 1.6104
	localparam real        IMP_LSB_OHM    = 62.5e-3;
	localparam real        CONV_DIVISOR   = 1.6104;
	localparam logic [5:0] RATING_OFFSET  = 6'h04;
	localparam logic [11:0] FACTOR_MULT   = 12'(int'(65536.0 * IMP_LSB_OHM / CONV_DIVISOR));

	// Headroom clamp: one headroom step of 187.5 mV is eight level units of 23.4375 mV
	localparam real         HEADROOM_STEP_MV      = 187.5;
	localparam logic [11:0] HEADROOM_LVL_PER_STEP = 12'h008;

endpackage

// [design/factor_calc.sv]
// Recomputes the impedance to drive conversion factor from a new measurement
`timescale 1ns/10ps
module factor_calc
(
	input  wire logic        i_clk,     // System clock
	input  wire logic        i_rst,     // Asynchronous reset, active high
	input  wire logic        i_start,   // New measurement present this cycle
	input  wire logic [9:0]  i_imp,     // Measured impedance, 62.5 mohm units
	input  wire logic [4:0]  i_rating,  // Current rating code
	output logic             o_valid,   // Result ready, one-cycle pulse
	output logic      [15:0] o_factor   // Computed factor
);

	logic [5:0]  rating_plus;
	logic [27:0] prod;

	// Fixed-point product; the divide by 1.6104 is folded into a Q16 multiplier
	assign rating_plus = {1'b0, i_rating} + haptic_cfg_pkg::RATING_OFFSET;
	assign prod        = 28'(i_imp) * 28'(rating_plus) * 28'(haptic_cfg_pkg::FACTOR_MULT);

	// One register stage keeps the multiplier off the register write path
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_valid  <= 1'b0;
			o_factor <= 16'h0000;
		end
		else
		begin
			o_valid <= i_start;
			if (i_start)
			begin
				o_factor <= {4'h0, prod[27:16]};
			end
		end
	end

endmodule // factor_calc

// [design/haptic_drive_config_regs.sv]
// Configuration and calibration register slice of the haptic actuator driver
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module haptic_drive_config_regs
(
	input  wire logic        i_clk,                    // System clock, 20 MHz
	input  wire logic        i_rst,                    // Asynchronous reset, active high
	input  wire logic [7:0]  i_addr,                   // Register address
	input  wire logic [7:0]  i_wdata,                  // Register write data
	input  wire logic        i_wr,                     // Write strobe
	input  wire logic        i_rd,                     // Read strobe
	output logic      [7:0]  o_rdata,                  // Read data, cycle after the strobe
	input  wire logic        i_meas_valid,             // Impedance measurement done, pulse
	input  wire logic [9:0]  i_meas_imp,               // Measured impedance, 62.5 mohm units
	input  wire logic        i_playing,                // Playback in progress
	input  wire logic [11:0] i_target_level,           // Requested drive level
	input  wire logic [11:0] i_supply_level,           // Present supply level
	input  wire logic [7:0]  i_nom_max,                // Nominal maximum voltage field
	input  wire logic [7:0]  i_abs_max,                // Absolute maximum voltage field
	output logic      [15:0] o_impedance_drive_factor, // Conversion factor
	output logic      [4:0]  o_current_rating_code,    // Current rating code
	output logic             o_auto_fault_clear,       // Device clears faults itself
	output logic             o_actuator_erm,           // Eccentric mass actuator selected
	output logic             o_backemf_loop_on,        // Back-EMF loop computations on
	output logic             o_freq_track_on,          // Resonance tracking active
	output logic             o_accel_on,               // Overdrive acceleration on
	output logic             o_fast_brake_on,          // Fast braking on
	output logic             o_amplitude_loop_on,      // Amplitude loop on
	output logic             o_mem_signed,             // Waveform memory holds signed data
	output logic      [3:0]  o_pwm_brake_threshold,    // PWM full-brake threshold code
	output logic             o_brake_threshold_on,     // Brake threshold in use
	output logic      [7:0]  o_full_scale,             // Full scale of unsigned waveforms
	output logic      [11:0] o_drive_level,            // Drive level after clamping
	output logic             o_drive_clamped_event     // Drive was clamped, pulse
);

	logic [4:0]  rating_q;
	logic [7:0]  factor_hi_q;
	logic [7:0]  factor_lo_q;
	logic [7:0]  imp_hi_q;
	logic [1:0]  imp_lo_q;
	logic [7:0]  drive_cfg_q;
	logic [4:0]  mem_brake_q;
	logic [3:0]  headroom_q;
	logic [7:0]  upd_ctl_q;
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;
	logic        calc_valid;
	logic [15:0] calc_factor;
	logic        upd_apply;
	logic        wr_factor;
	logic [11:0] headroom_lvl;
	logic [11:0] limit_lvl;
	logic        over_limit;
	logic [11:0] drive_level_q;
	logic        clamped_q;
	logic [7:0]  full_scale_q;

	// Address match used by every write; the read mux decodes the address in its own case
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction

	assign wr_factor = i_wr && (hit(i_addr, haptic_cfg_pkg::ADDR_FACTOR_HI) ||
		hit(i_addr, haptic_cfg_pkg::ADDR_FACTOR_LO));

	// Factor recompute runs whenever a measurement lands
	factor_calc u_factor_calc
	(
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_start  (i_meas_valid),
		.i_imp    (i_meas_imp),
		.i_rating (rating_q),
		.o_valid  (calc_valid),
		.o_factor (calc_factor)
	);

	// Permission is judged when the result is ready, so a hold set meanwhile still wins
	assign upd_apply = calc_valid && !upd_ctl_q[haptic_cfg_pkg::BIT_UPD_HOLD] &&
		!(upd_ctl_q[haptic_cfg_pkg::BIT_UPD_HOLD_PLAY] && i_playing);

	// Current rating code
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			rating_q <= haptic_cfg_pkg::RST_RATING;
		else if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_RATING))
			rating_q <= i_wdata[4:0];
	end

	// Factor bytes; a hardware update beats a software write in the same cycle
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			factor_hi_q <= haptic_cfg_pkg::RST_FACTOR_HI;
			factor_lo_q <= haptic_cfg_pkg::RST_FACTOR_LO;
		end
		else if (upd_apply)
		begin
			factor_hi_q <= calc_factor[15:8];
			factor_lo_q <= calc_factor[7:0];
		end
		else
		begin
			if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_FACTOR_HI))
				factor_hi_q <= i_wdata;
			if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_FACTOR_LO))
				factor_lo_q <= i_wdata;
		end
	end

	// Measured impedance, written only by the measurement, never by software
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			imp_hi_q <= haptic_cfg_pkg::RST_IMP_HI;
			imp_lo_q <= haptic_cfg_pkg::RST_IMP_LO;
		end
		else if (i_meas_valid)
		begin
			imp_hi_q <= i_meas_imp[9:2];
			imp_lo_q <= i_meas_imp[1:0];
		end
	end

	// Drive configuration; the reserved bit is masked so it always reads zero
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			drive_cfg_q <= haptic_cfg_pkg::RST_DRIVE_CFG;
		else if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_DRIVE_CFG))
			drive_cfg_q <= i_wdata & haptic_cfg_pkg::DRIVE_CFG_MASK;
	end

	// Memory format and PWM brake threshold
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			mem_brake_q <= haptic_cfg_pkg::RST_MEM_BRAKE;
		else if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_MEM_BRAKE))
			mem_brake_q <= i_wdata[4:0];
	end

	// Supply headroom code
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			headroom_q <= haptic_cfg_pkg::RST_HEADROOM;
		else if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_HEADROOM))
			headroom_q <= i_wdata[3:0];
	end

	// Update control; only the two hold bits exist
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			upd_ctl_q <= haptic_cfg_pkg::RST_UPD_CTL;
		else if (i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_UPD_CTL))
			upd_ctl_q <= i_wdata & haptic_cfg_pkg::UPD_CTL_MASK;
	end

	// Read mux; unmapped addresses answer zero
	always_comb
	begin
		rdata_d = haptic_cfg_pkg::RDATA_IDLE;
		case (i_addr)
			haptic_cfg_pkg::ADDR_RATING:    rdata_d = {3'h0, rating_q};
			haptic_cfg_pkg::ADDR_FACTOR_HI: rdata_d = factor_hi_q;
			haptic_cfg_pkg::ADDR_FACTOR_LO: rdata_d = factor_lo_q;
			haptic_cfg_pkg::ADDR_IMP_HI:    rdata_d = imp_hi_q;
			haptic_cfg_pkg::ADDR_IMP_LO:    rdata_d = {6'h00, imp_lo_q};
			haptic_cfg_pkg::ADDR_DRIVE_CFG: rdata_d = drive_cfg_q;
			haptic_cfg_pkg::ADDR_MEM_BRAKE: rdata_d = {3'h0, mem_brake_q};
			haptic_cfg_pkg::ADDR_HEADROOM:  rdata_d = {4'h0, headroom_q};
			haptic_cfg_pkg::ADDR_UPD_CTL:   rdata_d = upd_ctl_q;
			default:                        rdata_d = haptic_cfg_pkg::RDATA_IDLE;
		endcase
	end

	// Read data stands only in the cycle after each read strobe cycle, zero at all other times
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			rdata_q <= haptic_cfg_pkg::RDATA_IDLE;
		else if (i_rd)
			rdata_q <= rdata_d;
		else
			rdata_q <= haptic_cfg_pkg::RDATA_IDLE;
	end

	// Headroom in level units and the clamp limit, saturating at zero
	assign headroom_lvl = 12'({8'h00, headroom_q} * haptic_cfg_pkg::HEADROOM_LVL_PER_STEP);
	assign limit_lvl    = (i_supply_level > headroom_lvl) ? (i_supply_level - headroom_lvl) : 12'h000;
	assign over_limit   = (i_target_level >= limit_lvl);

	// Clamp stage; the event pulses once for each cycle the target sits at or over the limit
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			drive_level_q <= 12'h000;
			clamped_q     <= 1'b0;
		end
		else
		begin
			drive_level_q <= over_limit ? limit_lvl : i_target_level;
			clamped_q     <= over_limit;
		end
	end

	// Full scale of unsigned waveform data follows the acceleration enable
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			full_scale_q <= 8'h00;
		else
			full_scale_q <= drive_cfg_q[haptic_cfg_pkg::BIT_ACCEL] ? i_nom_max : i_abs_max;
	end

	// Outputs of the register file
	assign o_rdata                  = rdata_q;
	assign o_impedance_drive_factor = {factor_hi_q, factor_lo_q};
	assign o_current_rating_code    = rating_q;
	assign o_auto_fault_clear       = drive_cfg_q[haptic_cfg_pkg::BIT_AUTO_FAULT_CLR];
	assign o_actuator_erm           = drive_cfg_q[haptic_cfg_pkg::BIT_ACTUATOR_ERM];
	assign o_backemf_loop_on        = drive_cfg_q[haptic_cfg_pkg::BIT_BACKEMF_LOOP];
	assign o_accel_on               = drive_cfg_q[haptic_cfg_pkg::BIT_ACCEL];
	assign o_fast_brake_on          = drive_cfg_q[haptic_cfg_pkg::BIT_FAST_BRAKE];
	assign o_amplitude_loop_on      = drive_cfg_q[haptic_cfg_pkg::BIT_AMP_LOOP];
	assign o_mem_signed             = mem_brake_q[haptic_cfg_pkg::BIT_MEM_SIGNED];
	assign o_pwm_brake_threshold    = mem_brake_q[3:0];
	assign o_full_scale             = full_scale_q;
	assign o_drive_level            = drive_level_q;
	assign o_drive_clamped_event    = clamped_q;

	// Tracking is meaningless without a resonance, so eccentric mass forces it off
	assign o_freq_track_on = drive_cfg_q[haptic_cfg_pkg::BIT_FREQ_TRACK] &&
		!drive_cfg_q[haptic_cfg_pkg::BIT_ACTUATOR_ERM];

	// Code zero switches the brake threshold off
	assign o_brake_threshold_on = (mem_brake_q[3:0] != 4'h0);

	// Software write to the low byte shows in the factor next cycle unless hardware updates
	property p_factor_lo_write;
		@(posedge i_clk) disable iff (i_rst)
		(i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_FACTOR_LO) && !upd_apply)
		|=> (o_impedance_drive_factor[7:0] == $past(i_wdata)) && $stable(o_impedance_drive_factor[15:8]);
	endproperty
	a_factor_lo_write: assert property (p_factor_lo_write)
		else $error("Factor low byte write not reflected");

	// A ready result while frozen leaves the factor untouched
	property p_hold_blocks;
		@(posedge i_clk) disable iff (i_rst)
		(calc_valid && upd_ctl_q[haptic_cfg_pkg::BIT_UPD_HOLD] && !wr_factor)
		|=> $stable(o_impedance_drive_factor);
	endproperty
	a_hold_blocks: assert property (p_hold_blocks)
		else $error("Factor changed while updates were held");

	// A ready result during playback with the playback hold set is dropped
	property p_play_hold_blocks;
		@(posedge i_clk) disable iff (i_rst)
		(calc_valid && upd_ctl_q[haptic_cfg_pkg::BIT_UPD_HOLD_PLAY] && i_playing && !wr_factor)
		|=> $stable(o_impedance_drive_factor);
	endproperty
	a_play_hold_blocks: assert property (p_play_hold_blocks)
		else $error("Factor changed during playback hold");

	// Measurement to factor takes two cycles when updates are free
	property p_auto_update;
		@(posedge i_clk) disable iff (i_rst)
		(i_meas_valid && upd_ctl_q[7:6] == 2'b00)
		##1 (upd_ctl_q[7:6] == 2'b00)
		|=> (o_impedance_drive_factor == $past(calc_factor));
	endproperty
	a_auto_update: assert property (p_auto_update)
		else $error("Permitted factor update not applied");

	// Measurement appears in both read-only fields next cycle
	property p_meas_capture;
		@(posedge i_clk) disable iff (i_rst)
		i_meas_valid |=> ({imp_hi_q, imp_lo_q} == $past(i_meas_imp));
	endproperty
	a_meas_capture: assert property (p_meas_capture)
		else $error("Measured impedance not captured");

	// Eccentric mass never runs resonance tracking
	property p_erm_no_track;
		@(posedge i_clk) disable iff (i_rst)
		o_actuator_erm |-> !o_freq_track_on;
	endproperty
	a_erm_no_track: assert property (p_erm_no_track)
		else $error("Frequency tracking active for eccentric mass");

	// At or over the limit the drive is clamped and flagged
	property p_clamp;
		@(posedge i_clk) disable iff (i_rst)
		over_limit |=> o_drive_clamped_event && (o_drive_level == $past(limit_lvl));
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("Drive not clamped at supply minus headroom");

	// Under the limit the target passes unflagged
	property p_no_clamp;
		@(posedge i_clk) disable iff (i_rst)
		!over_limit |=> !o_drive_clamped_event && (o_drive_level == $past(i_target_level));
	endproperty
	a_no_clamp: assert property (p_no_clamp)
		else $error("Drive altered below the limit");

	// Headroom is eight level units per code step
	property p_headroom_scale;
		@(posedge i_clk) disable iff (i_rst)
		(headroom_q == 4'hf) |-> (headroom_lvl == 12'h078);
	endproperty
	a_headroom_scale: assert property (p_headroom_scale)
		else $error("Headroom scaling wrong");

	// Full scale follows the acceleration bit one cycle later
	property p_full_scale;
		@(posedge i_clk) disable iff (i_rst)
		##1 1'b1 |-> (o_full_scale == ($past(o_accel_on) ? $past(i_nom_max) : $past(i_abs_max)));
	endproperty
	a_full_scale: assert property (p_full_scale)
		else $error("Full scale source wrong");

	// Read data is zero in any cycle not following a read strobe
	property p_read_idle;
		@(posedge i_clk) disable iff (i_rst)
		!i_rd |=> (o_rdata == 8'h00);
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("Read data outside its cycle");

	// Bit 3 set with a resonant actuator turns tracking on
	property p_track_on;
		@(posedge i_clk) disable iff (i_rst)
		(i_wr && hit(i_addr, haptic_cfg_pkg::ADDR_DRIVE_CFG) && i_wdata[3] && !i_wdata[5])
		|=> o_freq_track_on ##1 (o_freq_track_on || $past(i_wr));
	endproperty
	a_track_on: assert property (p_track_on)
		else $error("Tracking not enabled");

endmodule // haptic_drive_config_regs

// [tb/testbench.sv]
// Self-checking testbench for the haptic drive configuration register slice
`timescale 1ns/10ps
module testbench;
	logic        i_clk;
	logic        i_rst;
	logic [7:0]  i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic        i_meas_valid;
	logic [9:0]  i_meas_imp;
	logic        i_playing;
	logic [11:0] i_target_level;
	logic [11:0] i_supply_level;
	logic [7:0]  i_nom_max;
	logic [7:0]  i_abs_max;
	logic [15:0] o_impedance_drive_factor;
	logic [4:0]  o_current_rating_code;
	logic        o_auto_fault_clear;
	logic        o_actuator_erm;
	logic        o_backemf_loop_on;
	logic        o_freq_track_on;
	logic        o_accel_on;
	logic        o_fast_brake_on;
	logic        o_amplitude_loop_on;
	logic        o_mem_signed;
	logic [3:0]  o_pwm_brake_threshold;
	logic        o_brake_threshold_on;
	logic [7:0]  o_full_scale;
	logic [11:0] o_drive_level;
	logic        o_drive_clamped_event;
	logic [7:0]  v;
	int          bad_count;
	int          num_checks;

	haptic_drive_config_regs dut
	(
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_meas_valid(i_meas_valid), .i_meas_imp(i_meas_imp), .i_playing(i_playing),
		.i_target_level(i_target_level), .i_supply_level(i_supply_level), .i_nom_max(i_nom_max),
		.i_abs_max(i_abs_max), .o_impedance_drive_factor(o_impedance_drive_factor),
		.o_current_rating_code(o_current_rating_code), .o_auto_fault_clear(o_auto_fault_clear),
		.o_actuator_erm(o_actuator_erm), .o_backemf_loop_on(o_backemf_loop_on),
		.o_freq_track_on(o_freq_track_on), .o_accel_on(o_accel_on), .o_fast_brake_on(o_fast_brake_on),
		.o_amplitude_loop_on(o_amplitude_loop_on), .o_mem_signed(o_mem_signed),
		.o_pwm_brake_threshold(o_pwm_brake_threshold), .o_brake_threshold_on(o_brake_threshold_on),
		.o_full_scale(o_full_scale), .o_drive_level(o_drive_level), .o_drive_clamped_event(o_drive_clamped_event)
	);

	// 20 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Strobe always lowered on its sampling edge, so calls never collide
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	// Factor from impedance code and rating, multiplier is the rounded constant
	function automatic logic [15:0] fexp(input logic [9:0] z, input logic [4:0] r);
		return 16'((32'(z) * (32'(r) + 32'd4) * 32'(haptic_cfg_pkg::FACTOR_MULT)) >> 16);
	endfunction

	task automatic meas(input logic [9:0] z);
		@(posedge i_clk);
		i_meas_valid <= 1'b1;
		i_meas_imp   <= z;
		@(posedge i_clk);
		i_meas_valid <= 1'b0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask

	task automatic clamp(input logic [11:0] t, input logic [11:0] s, input logic [11:0] lvl, input logic ev);
		@(posedge i_clk);
		i_target_level <= t;
		i_supply_level <= s;
		@(posedge i_clk);
		#1 check({3'h0, o_drive_clamped_event, o_drive_level}, {3'h0, ev, lvl});
	endtask

	task automatic test_reset();
		logic [7:0] tab [9] = '{8'h17, 8'h01, 8'h0d, 8'h00, 8'h00, 8'h1e, 8'h01, 8'h03, 8'h40};
		for (int i = 0; i < 9; i++)
		begin
			rd(8'h0e + 8'(i), v);
			check(v, tab[i]);
		end
		@(posedge i_clk);
		#1 check(o_rdata, 8'h00);
		check(o_impedance_drive_factor, 16'h010d);
		check({o_freq_track_on, o_brake_threshold_on, o_full_scale}, {2'b11, 8'h5a});
		$display("reset test done");
	endtask

	task automatic test_drive_cfg();
		wr(haptic_cfg_pkg::ADDR_DRIVE_CFG, 8'hff);
		rd(haptic_cfg_pkg::ADDR_DRIVE_CFG, v);
		check(v, 8'hbf);
		// ERM selected, so tracking is forced off although its bit is set
		check({o_auto_fault_clear, 1'b0, o_actuator_erm, o_backemf_loop_on, o_freq_track_on, o_accel_on,
			o_fast_brake_on, o_amplitude_loop_on}, 8'hb7);
		wr(haptic_cfg_pkg::ADDR_DRIVE_CFG, 8'h08);
		repeat (2) @(posedge i_clk);
		#1 check({o_auto_fault_clear, 1'b0, o_actuator_erm, o_backemf_loop_on, o_freq_track_on, o_accel_on,
			o_fast_brake_on, o_amplitude_loop_on}, 8'h08);
		check(o_full_scale, 8'h78);
		wr(haptic_cfg_pkg::ADDR_DRIVE_CFG, 8'h1e);
		repeat (2) @(posedge i_clk);
		#1 check(o_full_scale, 8'h5a);
		$display("drive config test done");
	endtask

	task automatic test_regs();
		// Factor software would program for a 100 ohm actuator at the reset rating code, rounded
		wr(haptic_cfg_pkg::ADDR_FACTOR_HI, 8'h06);
		wr(haptic_cfg_pkg::ADDR_FACTOR_LO, 8'h8d);
		#1 check(o_impedance_drive_factor, 16'h068d);
		rd(haptic_cfg_pkg::ADDR_FACTOR_LO, v);
		check(v, 8'h8d);
		wr(haptic_cfg_pkg::ADDR_IMP_HI, 8'hff);
		wr(haptic_cfg_pkg::ADDR_IMP_LO, 8'hff);
		rd(haptic_cfg_pkg::ADDR_IMP_HI, v);
		check(v, 8'h00);
		rd(8'h20, v);
		check(v, 8'h00);
		// Signed memory data only goes with acceleration switched off
		wr(haptic_cfg_pkg::ADDR_DRIVE_CFG, 8'h1a);
		wr(haptic_cfg_pkg::ADDR_MEM_BRAKE, 8'h10);
		#1 check({o_accel_on, o_mem_signed, o_brake_threshold_on, o_pwm_brake_threshold}, 7'h20);
		wr(haptic_cfg_pkg::ADDR_DRIVE_CFG, 8'h1e);
		wr(haptic_cfg_pkg::ADDR_MEM_BRAKE, 8'h0f);
		rd(haptic_cfg_pkg::ADDR_MEM_BRAKE, v);
		check({o_mem_signed, o_brake_threshold_on, o_pwm_brake_threshold, v}, 14'h1f0f);
		wr(haptic_cfg_pkg::ADDR_UPD_CTL, 8'hff);
		rd(haptic_cfg_pkg::ADDR_UPD_CTL, v);
		check(v, 8'hc0);
		$display("register test done");
	endtask

	task automatic test_measure();
		wr(haptic_cfg_pkg::ADDR_UPD_CTL, 8'h00);
		wr(haptic_cfg_pkg::ADDR_RATING, 8'hff);
		rd(haptic_cfg_pkg::ADDR_RATING, v);
		check({v, 3'h0, o_current_rating_code}, 16'h1f1f);
		meas(10'h3a7);
		check(o_impedance_drive_factor, fexp(10'h3a7, 5'h1f));
		rd(haptic_cfg_pkg::ADDR_IMP_HI, v);
		check(v, 8'he9);
		rd(haptic_cfg_pkg::ADDR_IMP_LO, v);
		check(v, 8'h03);
		rd(haptic_cfg_pkg::ADDR_FACTOR_LO, v);
		check(v, fexp(10'h3a7, 5'h1f) & 16'h00ff);
		wr(haptic_cfg_pkg::ADDR_UPD_CTL, 8'h80);
		meas(10'h155);
		check(o_impedance_drive_factor, fexp(10'h3a7, 5'h1f));
		// Held during playback only: blocked while playing, allowed once stopped
		wr(haptic_cfg_pkg::ADDR_UPD_CTL, 8'h40);
		@(posedge i_clk);
		i_playing <= 1'b1;
		meas(10'h2aa);
		check(o_impedance_drive_factor, fexp(10'h3a7, 5'h1f));
		@(posedge i_clk);
		i_playing <= 1'b0;
		meas(10'h2aa);
		check(o_impedance_drive_factor, fexp(10'h2aa, 5'h1f));
		$display("measurement test done");
	endtask

	task automatic test_clamp();
		wr(haptic_cfg_pkg::ADDR_HEADROOM, 8'hff);
		rd(haptic_cfg_pkg::ADDR_HEADROOM, v);
		check(v, 8'h0f);
		clamp(12'h387, 12'h400, 12'h387, 1'b0);
		clamp(12'h388, 12'h400, 12'h388, 1'b1);
		wr(haptic_cfg_pkg::ADDR_HEADROOM, 8'h03);
		clamp(12'h3e7, 12'h400, 12'h3e7, 1'b0);
		clamp(12'hfff, 12'h400, 12'h3e8, 1'b1);
		clamp(12'h005, 12'h010, 12'h000, 1'b1);
		$display("clamp test done");
	endtask

	// Main sequence, all inputs defined from time zero
	initial
	begin
		bad_count = 0;
		num_checks = 0;
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_meas_valid = 1'b0;
		i_meas_imp = 10'h000;
		i_playing = 1'b0;
		i_target_level = 12'h000;
		i_supply_level = 12'h400;
		i_nom_max = 8'h5a;
		i_abs_max = 8'h78;
		repeat (12) @(posedge i_clk);
		i_rst <= 1'b0;
		test_reset();
		test_drive_cfg();
		test_regs();
		test_measure();
		test_clamp();
		conclude();
	end

	// Watchdog: a hang counts as a mismatch
	initial
	begin
		#2000000;
		bad_count++;
		conclude();
	end
endmodule // testbench
